// File: src/ams_pkg.sv
package ams_pkg;
  localparam int NCH = 3;
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int RAMP_FULL_MS = 20_000;
  localparam int OUT_FULL = 1000;
  localparam int RAMP_CYC = RAMP_FULL_MS * (1_000_000 / CLK_NS) / OUT_FULL;
  localparam int FULL_SCALE = 4000;
  localparam int THR_MAX = FULL_SCALE * 110 / 100;
  localparam int HYS_MIN = 1;
  localparam int HYS_MAX = 100;
  localparam int HYS_DIV = 1000;
  localparam int LSD = 1;
  localparam int BLINK_TICKS = 5;
  localparam logic [5:0] FILT_TICKS [8] = '{6'h00, 6'h04, 6'h0A, 6'h14, 6'h1E, 6'h28, 6'h32, 6'h32};

  localparam logic [7:0] A_CFG0 = 8'h00;
  localparam logic [7:0] A_THR0 = 8'h0C;
  localparam logic [7:0] A_HYS0 = 8'h18;
  localparam logic [7:0] A_CTRL = 8'h24;
  localparam logic [7:0] A_SP = 8'h28;
  localparam logic [7:0] A_SBLIM = 8'h2C;
  localparam logic [7:0] A_SBREC = 8'h30;
  localparam logic [7:0] A_PB = 8'h34;
  localparam logic [7:0] A_TI = 8'h38;
  localparam logic [7:0] A_TD = 8'h3C;
  localparam logic [7:0] A_STAT = 8'h40;
  localparam logic [7:0] A_OUT = 8'h44;

  localparam int CFG_TYPE = 0;
  localparam int CFG_DIR = 2;
  localparam int CFG_LATCH = 4;
  localparam int CFG_FSAFE = 5;
  localparam int CFG_FILT = 6;
  localparam int CTRL_SRC = 0;
  localparam int CTRL_FIT = 1;
  localparam int CTRL_KPMAN = 2;
  localparam int CTRL_TUNE = 3;
  localparam int CTRL_SBY = 4;
  localparam int CTRL_MSK = 5;
  localparam int CTRL_ARST = 6;

  localparam logic [8:0] CFG_RST = 9'h020;
  localparam logic [6:0] HYS_RST = 7'h01;

  typedef enum logic [1:0] {TYP_PROC, TYP_DEV, TYP_BAND} ams_type_e;
  typedef enum logic [1:0] {DIR_HIGH, DIR_LOW, DIR_LOWINH} ams_dir_e;
  typedef enum logic [1:0] {TN_OFF, TN_STEP, TN_ADAPT} ams_tune_e;
  typedef enum logic [1:0] {SB_RUN, SB_FREEZE, SB_WAIT, SB_ZERO} ams_sby_e;
endpackage

// File: src/ams_alarm_ch.sv
`timescale 1ns/1ps
module ams_alarm_ch
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic eval,
  input wire logic [8:0] cfg,
  input wire logic [15:0] thr,
  input wire logic [6:0] hys,
  input wire logic [15:0] pv,
  input wire logic [15:0] sp,
  input wire logic rearm,
  input wire logic alarm_reset,
  output logic active,
  output logic relay
);
  import ams_pkg::*;

  typedef struct packed {
    logic active;
    logic relay;
    logic mask;
    logic seen;
    logic rpend;
    logic [5:0] fcnt;
  } ams_ch_s;

  ams_ch_s st_q;
  ams_ch_s st_d;
  ams_type_e typ;
  ams_dir_e dir;
  logic signed [17:0] dev;
  logic signed [17:0] val;
  logic signed [17:0] tv;
  logic signed [17:0] hv;
  logic [31:0] hprod;
  logic [5:0] need;
  logic high;
  logic set_c;
  logic clr_c;

  assign typ = ams_type_e'(cfg[CFG_TYPE +: 2]);
  assign dir = ams_dir_e'(cfg[CFG_DIR +: 2]);
  assign active = st_q.active;
  assign relay = st_q.relay;

  always_comb
  begin
    st_d = st_q;
    dev = $signed({2'h0, pv}) - $signed({2'h0, sp});
    if (typ == TYP_PROC)
      val = $signed({2'h0, pv});
    else if (typ == TYP_BAND && dev < 0)
      val = -dev;
    else
      val = dev;
    hprod = 32'(hys) * 32'(FULL_SCALE) / 32'(HYS_DIV);
    hv = (hprod < 32'(LSD)) ? 18'(LSD) : 18'(hprod);
    high = (dir == DIR_HIGH);
    tv = (typ == TYP_DEV && !high) ? -$signed({2'h0, thr}) : $signed({2'h0, thr});
    set_c = high ? (val > tv) : (val < tv);
    clr_c = high ? (val <= tv - hv) : (val >= tv + hv);
    need = FILT_TICKS[cfg[CFG_FILT +: 3]];
    if (alarm_reset)
      st_d.rpend = 1'b1;
    if (tick && st_q.seen && st_q.fcnt < need)
      st_d.fcnt = st_q.fcnt + 6'h01;
    if (eval)
    begin
      st_d.seen = set_c;
      st_d.rpend = 1'b0;
      if (!set_c)
      begin
        st_d.fcnt = 6'h00;
        st_d.mask = 1'b0;
      end
      if (set_c && st_q.fcnt >= need && !(st_q.mask && dir == DIR_LOWINH))
        st_d.active = 1'b1;
      else if (st_q.active && clr_c && (!cfg[CFG_LATCH] || st_q.rpend || alarm_reset))
        st_d.active = 1'b0;
    end
    // Re-arming outranks the release of the mask in the same cycle.
    if (rearm)
      st_d.mask = 1'b1;
    st_d.relay = cfg[CFG_FSAFE] ? !st_d.active : st_d.active;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.mask <= 1'b1;
      st_q.relay <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  AST_RELAY_POL: assert property (@(posedge clk) disable iff (rst)
    relay == ($past(cfg[CFG_FSAFE]) ? !active : active)) else $error("Relay polarity wrong.");
  AST_EVAL_ONLY: assert property (@(posedge clk) disable iff (rst)
    !eval |=> $stable(active)) else $error("Alarm changed without a conversion.");
  AST_HYS_CLR: assert property (@(posedge clk) disable iff (rst)
    $fell(active) |-> $past(clr_c) && $past(eval)) else $error("Alarm cleared inside hysteresis.");
  AST_FILTER: assert property (@(posedge clk) disable iff (rst)
    $rose(active) |-> $past(st_q.fcnt >= need)) else $error("Alarm set before filter time.");
  AST_LATCH: assert property (@(posedge clk) disable iff (rst)
    $fell(active) && $past(cfg[CFG_LATCH]) |-> $past(st_q.rpend || alarm_reset))
    else $error("Latched alarm cleared without reset.");
endmodule

// File: src/ams_supervisor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module ams_supervisor
#(
  parameter int TICK_CYCLES = ams_pkg::TICK_CYC,
  parameter int RAMP_CYCLES = ams_pkg::RAMP_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pv,
  input wire logic pv_valid,
  input wire logic sp_ramp,
  input wire logic [9:0] pid_out,
  input wire logic tune_done,
  input wire logic nv_adaptive,
  input wire logic auto_manual_contact,
  input wire logic output_raise_contact,
  input wire logic output_lower_contact,
  input wire logic forced_manual_zero_contact,
  output logic [ams_pkg::NCH-1:0] alarm_relay,
  output logic [ams_pkg::NCH-1:0] alarm_led,
  output logic manual_led,
  output logic tuning_indicator,
  output logic [9:0] ctrl_out,
  output logic pid_preload,
  output logic nv_adaptive_save,
  output logic [15:0] proportional_band,
  output logic [15:0] integral_time,
  output logic [15:0] derivative_time
);
  import ams_pkg::*;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic frc_prev;
    logic manual;
    logic [9:0] out;
    logic [21:0] ramp_cnt;
    logic [21:0] tick_cnt;
    logic tick;
    logic [2:0] blink_cnt;
    logic blink;
    logic [NCH-1:0][8:0] cfg;
    logic [NCH-1:0][15:0] thr;
    logic [NCH-1:0][6:0] hys;
    logic src;
    logic fit;
    logic kpman;
    logic sby;
    ams_tune_e tune;
    ams_sby_e sb;
    logic [17:0] sb_cnt;
    logic [9:0] stable;
    logic preload;
    logic [15:0] sp;
    logic [15:0] sblim;
    logic [15:0] sbrec;
    logic [15:0] pb;
    logic [15:0] ti;
    logic [15:0] td;
    logic msk;
    logic arst;
    logic spchg;
    logic boot;
    logic [31:0] prdata;
  } ams_top_s;

  ams_top_s st_q;
  ams_top_s st_d;
  logic wr;
  logic hit;
  logic kp_wr;
  logic frc;
  logic frc_rise;
  logic rl_on;
  logic step;
  logic pv_low;
  logic sat;
  logic [17:0] wait_lim;
  logic [31:0] rd;
  logic [NCH-1:0] rearm;
  logic [NCH-1:0] act;

  ////////////////////////////////////////////////////////////////////////////////

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    assign rearm[g] = st_q.msk | ((st_q.cfg[g][CFG_TYPE +: 2] != 2'(TYP_PROC)) & (st_q.spchg | sp_ramp));
    ams_alarm_ch u_ch (
      .clk(clk),
      .rst(rst),
      .tick(st_q.tick),
      .eval(pv_valid),
      .cfg(st_q.cfg[g]),
      .thr(st_q.thr[g]),
      .hys(st_q.hys[g]),
      .pv(pv),
      .sp(st_q.sp),
      .rearm(rearm[g]),
      .alarm_reset(st_q.arst),
      .active(act[g]),
      .relay(alarm_relay[g])
    );
  end

  assign alarm_led = act;
  assign manual_led = st_q.manual;
  assign ctrl_out = st_q.out;
  assign pid_preload = st_q.preload;
  assign proportional_band = st_q.pb;
  assign integral_time = st_q.ti;
  assign derivative_time = st_q.td;
  assign nv_adaptive_save = (st_q.tune == TN_ADAPT);
  assign tuning_indicator = (st_q.tune == TN_ADAPT) | ((st_q.tune == TN_STEP) & st_q.blink);
  assign prdata = st_q.prdata;
  // Every access completes in its first access cycle, so no wait states.
  assign pready = 1'b1;
  assign pslverr = psel & penable & !hit;
  assign wr = psel & penable & pwrite;
  assign kp_wr = wr & (paddr == A_OUT);
  assign frc = st_q.sy2[3];
  assign frc_rise = frc & !st_q.frc_prev;
  assign pv_low = pv < st_q.sblim;
  assign sat = pid_out >= 10'(OUT_FULL);
  assign wait_lim = 18'((32'(st_q.ti) * 32'h0000_0005) >> 1);

  ////////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    st_d = st_q;
    hit = 1'b0;
    rd = 32'h0000_0000;
    step = 1'b0;
    st_d.msk = 1'b0;
    st_d.arst = 1'b0;
    st_d.spchg = 1'b0;
    st_d.preload = 1'b0;
    // Only the second stage of the contact synchroniser is used anywhere.
    st_d.sy1 = {forced_manual_zero_contact, output_lower_contact, output_raise_contact, auto_manual_contact};
    st_d.sy2 = st_q.sy1;
    st_d.frc_prev = frc;

    for (int i = 0; i < NCH; i++)
    begin
      if (paddr == A_CFG0 + 8'(4 * i))
      begin
        hit = 1'b1;
        rd = {23'h00_0000, st_q.cfg[i]};
        if (wr)
          st_d.cfg[i] = pwdata[8:0];
      end
      if (paddr == A_THR0 + 8'(4 * i))
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.thr[i]};
        if (wr)
          st_d.thr[i] = (pwdata > 32'(THR_MAX)) ? 16'(THR_MAX) : pwdata[15:0];
      end
      if (paddr == A_HYS0 + 8'(4 * i))
      begin
        hit = 1'b1;
        rd = {25'h000_0000, st_q.hys[i]};
        if (wr && pwdata < 32'(HYS_MIN))
          st_d.hys[i] = 7'(HYS_MIN);
        else if (wr)
          st_d.hys[i] = (pwdata > 32'(HYS_MAX)) ? 7'(HYS_MAX) : pwdata[6:0];
      end
    end

    case (paddr)
      A_CTRL:
      begin
        hit = 1'b1;
        rd = {27'h000_0000, st_q.sby, st_q.tune != TN_OFF, st_q.kpman, st_q.fit, st_q.src};
        if (wr)
        begin
          st_d.src = pwdata[CTRL_SRC];
          st_d.fit = pwdata[CTRL_FIT];
          st_d.kpman = pwdata[CTRL_KPMAN];
          st_d.sby = pwdata[CTRL_SBY];
          st_d.msk = pwdata[CTRL_MSK];
          st_d.arst = pwdata[CTRL_ARST];
          if (!pwdata[CTRL_TUNE])
            st_d.tune = TN_OFF;
          else if (st_q.tune == TN_OFF)
            st_d.tune = st_q.manual ? TN_STEP : TN_ADAPT;
        end
      end
      A_SP:
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.sp};
        if (wr)
        begin
          st_d.sp = pwdata[15:0];
          st_d.spchg = (pwdata[15:0] != st_q.sp);
        end
      end
      A_SBLIM:
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.sblim};
        if (wr)
          st_d.sblim = pwdata[15:0];
      end
      A_SBREC:
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.sbrec};
        if (wr)
          st_d.sbrec = pwdata[15:0];
      end
      A_PB:
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.pb};
        if (wr && st_q.tune != TN_ADAPT)
          st_d.pb = pwdata[15:0];
      end
      A_TI:
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.ti};
        if (wr && st_q.tune != TN_ADAPT)
          st_d.ti = pwdata[15:0];
      end
      A_TD:
      begin
        hit = 1'b1;
        rd = {16'h0000, st_q.td};
        if (wr && st_q.tune != TN_ADAPT)
          st_d.td = pwdata[15:0];
      end
      A_STAT:
      begin
        hit = 1'b1;
        rd = {23'h00_0000, st_q.tune, st_q.sb, frc, st_q.manual, act};
      end
      A_OUT:
      begin
        hit = 1'b1;
        rd = {22'h00_0000, st_q.out};
      end
      default:
      begin
        // Channel registers were decoded by the loop above and keep their hit.
      end
    endcase
    if (psel && !penable)
      st_d.prdata = rd;

    // Time base of 0.1 s shared by filters, stand-by and the indicator.
    st_d.tick = (st_q.tick_cnt == 22'(TICK_CYCLES - 1));
    st_d.tick_cnt = st_d.tick ? 22'h00_0000 : st_q.tick_cnt + 22'h00_0001;
    if (st_q.tick)
    begin
      st_d.blink_cnt = st_q.blink_cnt + 3'h1;
      if (st_q.blink_cnt == 3'(BLINK_TICKS - 1))
      begin
        st_d.blink_cnt = 3'h0;
        st_d.blink = !st_q.blink;
      end
    end

    // The forced contact overrides every other mode source while closed.
    st_d.manual = frc | (st_q.fit ? st_q.sy2[0] : st_q.kpman);

    rl_on = st_q.manual & st_q.src & st_q.fit & (st_q.sy2[1] ^ st_q.sy2[2]);
    if (rl_on)
    begin
      step = (st_q.ramp_cnt == 22'(RAMP_CYCLES - 1));
      st_d.ramp_cnt = step ? 22'h00_0000 : st_q.ramp_cnt + 22'h00_0001;
    end
    else
      st_d.ramp_cnt = 22'h00_0000;

    if (st_q.boot)
    begin
      st_d.boot = 1'b0;
      if (nv_adaptive)
        st_d.tune = TN_ADAPT;
    end
    if (st_d.tune == TN_STEP && (tune_done || !st_d.manual))
      st_d.tune = TN_OFF;

    if (st_q.sb == SB_RUN && pv_valid && !pv_low && !sat)
      st_d.stable = pid_out;
    if (!st_q.sby || st_d.manual)
    begin
      st_d.sb = SB_RUN;
      st_d.sb_cnt = 18'h0_0000;
    end
    else
    begin
      if (st_q.tick && st_q.sb_cnt != 18'h3_FFFF)
        st_d.sb_cnt = st_q.sb_cnt + 18'h0_0001;
      unique case (st_q.sb)
        SB_RUN:
        begin
          st_d.sb_cnt = 18'h0_0000;
          if (pv_valid && pv_low && sat)
            st_d.sb = SB_FREEZE;
        end
        SB_FREEZE:
        begin
          if (pv_valid && !pv_low)
          begin
            st_d.sb = SB_WAIT;
            st_d.sb_cnt = 18'h0_0000;
          end
          else if (st_q.sb_cnt >= 18'(st_q.sbrec))
            st_d.sb = SB_ZERO;
        end
        SB_ZERO:
        begin
          if (pv_valid && !pv_low)
          begin
            st_d.sb = SB_WAIT;
            st_d.sb_cnt = 18'h0_0000;
          end
        end
        SB_WAIT:
        begin
          if (st_q.sb_cnt >= wait_lim)
          begin
            st_d.sb = SB_RUN;
            st_d.preload = 1'b1;
          end
        end
      endcase
    end

    if (frc_rise)
      st_d.out = 10'h000;
    else if (!st_d.manual)
    begin
      if (st_d.sb == SB_ZERO)
        st_d.out = 10'h000;
      else if (st_d.sb != SB_RUN || st_d.preload)
        st_d.out = st_d.stable;
      else
        st_d.out = sat ? 10'(OUT_FULL) : pid_out;
    end
    else if (kp_wr)
      st_d.out = (pwdata > 32'(OUT_FULL)) ? 10'(OUT_FULL) : pwdata[9:0];
    else if (step && st_q.sy2[1] && st_q.out < 10'(OUT_FULL))
      st_d.out = st_q.out + 10'h001;
    else if (step && st_q.sy2[2] && st_q.out != 10'h000)
      st_d.out = st_q.out - 10'h001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.cfg <= {NCH{CFG_RST}};
      st_q.hys <= {NCH{HYS_RST}};
      st_q.boot <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////////

  AST_FORCED_ZERO: assert property (@(posedge clk) disable iff (rst)
    frc_rise |=> ctrl_out == 10'h000 && manual_led) else $error("Forced contact did not zero output.");
  AST_AM_CONTACT: assert property (@(posedge clk) disable iff (rst)
    !frc && st_q.fit |=> manual_led == $past(st_q.sy2[0])) else $error("Mode does not follow contact.");
  AST_RL_IGNORED: assert property (@(posedge clk) disable iff (rst)
    st_q.manual && st_d.manual && !st_q.src && !kp_wr && !frc_rise |=> $stable(ctrl_out))
    else $error("Output moved without contact source.");
  AST_TUNE_MAN: assert property (@(posedge clk) disable iff (rst)
    st_q.tune == TN_STEP |-> st_q.manual) else $error("Step tuning outside manual.");
  AST_TUNE_IND: assert property (@(posedge clk) disable iff (rst)
    st_q.tune == TN_ADAPT |-> tuning_indicator) else $error("Adaptive indicator not steady.");
  AST_PID_LOCK: assert property (@(posedge clk) disable iff (rst)
    wr && paddr == A_TI && st_q.tune == TN_ADAPT |=> $stable(integral_time))
    else $error("Integral time written during adaptive.");
  AST_SBY_FREEZE: assert property (@(posedge clk) disable iff (rst)
    st_d.sb == SB_FREEZE && !st_d.manual && !frc_rise |=> ctrl_out == st_q.stable)
    else $error("Stand-by output not frozen.");
  AST_SBY_ZERO: assert property (@(posedge clk) disable iff (rst)
    st_d.sb == SB_ZERO && !st_d.manual |=> ctrl_out == 10'h000) else $error("Stand-by output not zero.");
  AST_SBY_WAIT: assert property (@(posedge clk) disable iff (rst)
    st_q.sby && !st_d.manual && st_q.sb == SB_WAIT && st_d.sb == SB_RUN |-> st_q.sb_cnt >= wait_lim)
    else $error("Stand-by resumed too early.");
endmodule

// File: tb/ams_field_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Sensor side: one conversion every gap+1 cycles, none while gap is zero.
// Between conversions the value bus carries junk, so only pv_valid qualifies it.
module ams_field_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] level,
  input wire logic [7:0] gap,
  output logic [15:0] pv = 16'h0000,
  output logic pv_valid = 1'b0
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge clk)
  begin
    pv_valid <= 1'b0;
    pv <= ~pv;
    cnt_q <= cnt_q + 8'h01;
    if (rst || gap == 8'h00)
      cnt_q <= 8'h00;
    else if (cnt_q >= gap)
    begin
      cnt_q <= 8'h00;
      pv_valid <= 1'b1;
      pv <= level;
    end
  end
endmodule

// File: tb/tb_alarm_and_mode_supervisor.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_alarm_and_mode_supervisor;
  import ams_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err, e;
  logic pv_valid, sp_ramp = 1'b0, nv_adaptive = 1'b0, tune_done = 1'b0, pid_preload, nv_save, manual_led;
  logic am = 1'b0, up = 1'b0, dn = 1'b0, fz = 1'b0, tuning_indicator;
  logic [7:0] paddr = 8'h00, gap = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
  logic [15:0] pv, pb_o, ti_o, td_o, level = 16'h0000;
  logic [9:0] pid_out = 10'h000, ctrl_out, c0;
  logic [2:0] alarm_relay, alarm_led;
  logic [7:0] ra [3] = '{8'h14, 8'h20, 8'h20};
  logic [31:0] wd [3] = '{32'h0000_FFFF, 32'h0000_0000, 32'h0000_00C8};
  logic [31:0] ex [3] = '{32'h0000_1130, 32'h0000_0001, 32'h0000_0064};
  int cv [6] = '{1000, 1001, 961, 960, 1001, 1000};
  int n_fail = 0, tests_run = 0, n = 0, cyc = 0;

  ams_supervisor #(.TICK_CYCLES(20), .RAMP_CYCLES(10)) uut
  (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pv(pv), .pv_valid(pv_valid),
    .sp_ramp(sp_ramp), .pid_out(pid_out), .tune_done(tune_done), .nv_adaptive(nv_adaptive),
    .auto_manual_contact(am), .output_raise_contact(up), .output_lower_contact(dn),
    .forced_manual_zero_contact(fz), .alarm_relay(alarm_relay), .alarm_led(alarm_led),
    .manual_led(manual_led), .tuning_indicator(tuning_indicator), .ctrl_out(ctrl_out),
    .pid_preload(pid_preload), .nv_adaptive_save(nv_save), .proportional_band(pb_o),
    .integral_time(ti_o), .derivative_time(td_o)
  );
  ams_field_model field
  (
    .clk(clk), .rst(rst), .level(level), .gap(gap), .pv(pv), .pv_valid(pv_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("fails=%0d checks=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // The request is held until pready is seen; only the global cycle limit ends a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Two edges first, so the next conversion surely carries the new level.
  task automatic conv(input logic [15:0] v);
    level <= v;
    repeat (2) @(posedge clk);
    do @(posedge clk); while (pv_valid !== 1'b1);
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_for_led();
    n = 0;
    while (alarm_led[0] !== 1'b1 && n < 1200)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  function automatic logic hi_alarm(logic p, int v, int t, int hy);
    int h;
    h = (hy * FULL_SCALE / HYS_DIV > LSD) ? hy * FULL_SCALE / HYS_DIV : LSD;
    return v > (p ? t - h : t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h08BA_6145));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({alarm_relay, alarm_led}, 6'h38)
    rd(A_CFG0);
    `CHK(rdv, 32'h0000_0020)
    rd(A_HYS0);
    `CHK(rdv, 32'h0000_0001)
    rd(8'h80);
    `CHK({err, rdv}, 33'h1_0000_0000)
    for (int i = 0; i < 3; i++)
    begin
      wr(ra[i], wd[i]);
      rd(ra[i]);
      `CHK(rdv, ex[i])
    end
    wr(A_THR0, 32'h0000_03E8);
    wr(A_HYS0, 32'h0000_000A);
    wr(A_CFG0 + 8'h04, 32'h0000_0028);
    wr(A_THR0 + 8'h04, 32'h0000_01F4);
    gap <= 8'h06;
    conv(16'h0190);
    `CHK(alarm_led[1], 1'b0)
    e = 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      n = (i < 6) ? cv[i] : 900 + $urandom_range(150);
      conv(n[15:0]);
      e = hi_alarm(e, n, 1000, 10);
      `CHK({alarm_led[0], alarm_relay[0]}, {e, ~e})
    end
    conv(16'h0190);
    `CHK({alarm_led[1], alarm_relay[1]}, 2'h2)
    conv(16'h0258);
    wr(A_CTRL, 32'h0000_0020);
    conv(16'h0190);
    `CHK(alarm_led[1], 1'b0)
    wr(A_SP, 32'h0000_03E8);
    wr(A_THR0, 32'h0000_0064);
    wr(A_CFG0, 32'h0000_0021);
    conv(16'h044D);
    `CHK(alarm_led[0], 1'b1)
    conv(16'h041A);
    `CHK(alarm_led[0], 1'b0)
    wr(A_CFG0, 32'h0000_0022);
    conv(16'h0352);
    `CHK(alarm_led[0], 1'b1)
    wr(A_CFG0 + 8'h04, 32'h0000_0029);
    sp_ramp <= 1'b1;
    conv(16'h0190);
    `CHK(alarm_led[1], 1'b0)
    sp_ramp <= 1'b0;
    conv(16'h07D0);
    conv(16'h0190);
    `CHK(alarm_led[1], 1'b1)
    wr(A_THR0 + 8'h08, 32'h0000_07D0);
    wr(A_CFG0 + 8'h08, 32'h0000_0010);
    conv(16'h07D1);
    `CHK(alarm_relay[2], 1'b1)
    conv(16'h0064);
    `CHK(alarm_led[2], 1'b1)
    wr(A_CTRL, 32'h0000_0040);
    conv(16'h0064);
    `CHK({alarm_led[2], alarm_relay[2]}, 2'h0)
    for (int f = 1; f < 7; f++)
    begin
      wr(A_CFG0, 32'h0000_0020 | (f << 6));
      conv(16'h0000);
      level <= 16'h07D0;
      wait_for_led();
      `CHK(n >= (FILT_TICKS[f] - 1) * 20 && n <= FILT_TICKS[f] * 20 + 30, 1'b1)
    end
    wr(A_CTRL, 32'h0000_0002);
    am <= 1'b1;
    up <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(manual_led, 1'b1)
    c0 = ctrl_out;
    repeat (60) @(posedge clk);
    `CHK(ctrl_out, c0)
    wr(A_CTRL, 32'h0000_0003);
    c0 = ctrl_out;
    repeat (100) @(posedge clk);
    up <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(ctrl_out - c0 >= 9 && ctrl_out - c0 <= 11, 1'b1)
    fz <= 1'b1;
    am <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({manual_led, ctrl_out}, 11'h400)
    wr(A_OUT, 32'h0000_012C);
    `CHK(ctrl_out, 10'h12C)
    dn <= 1'b1;
    repeat (100) @(posedge clk);
    dn <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(10'h12C - ctrl_out >= 9 && 10'h12C - ctrl_out <= 11, 1'b1)
    fz <= 1'b0;
    am <= 1'b1;
    repeat (4) @(posedge clk);
    wr(A_CTRL, 32'h0000_000A);
    n = 0;
    e = tuning_indicator;
    repeat (400)
    begin
      @(posedge clk);
      n += (tuning_indicator !== e);
      e = tuning_indicator;
    end
    `CHK(n >= 3 && n <= 5, 1'b1)
    tune_done <= 1'b1;
    @(posedge clk);
    tune_done <= 1'b0;
    repeat (3) @(posedge clk);
    rd(A_CTRL);
    `CHK({tuning_indicator, rdv[3]}, 2'h0)
    am <= 1'b0;
    wr(A_PB, 32'h0000_0037);
    wr(A_CTRL, 32'h0000_000A);
    repeat (150) @(posedge clk);
    `CHK({tuning_indicator, nv_save}, 2'h3)
    wr(A_PB, 32'h0000_007B);
    rd(A_PB);
    `CHK(rdv, 32'h0000_0037)
    `CHK(pb_o, 16'h0037)
    wr(A_TD, 32'h0000_0011);
    `CHK(td_o, 16'h0000)
    wr(A_CTRL, 32'h0000_0012);
    wr(A_SBLIM, 32'h0000_01F4);
    wr(A_SBREC, 32'h0000_0002);
    wr(A_TI, 32'h0000_0002);
    `CHK(ti_o, 16'h0002)
    pid_out <= 10'h1F4;
    conv(16'h0320);
    pid_out <= 10'h3E8;
    conv(16'h0064);
    rd(A_STAT);
    `CHK({rdv[6:5], ctrl_out}, {2'h1, 10'h1F4})
    repeat (60) @(posedge clk);
    rd(A_STAT);
    `CHK({rdv[6:5], ctrl_out}, {2'h3, 10'h000})
    conv(16'h0320);
    n = 0;
    while (pid_preload !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n >= 70 && n <= 140, 1'b1)
    nv_adaptive <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({nv_save, tuning_indicator, alarm_relay}, 5'h1F)
    give_verdict();
  end
endmodule
